/* File: src/output_action_unit.sv */
// one output pin driven by three event sources through two-bit action codes
// assumes: events are one-cycle pulses on core_clk
`timescale 1ns/1ps
`include "timer_cfg.svh"
module output_action_unit (
  input  wire logic              core_clk,
  input  wire logic              rst,
  input  wire timer_pkg::action_t code_cmp0,
  input  wire timer_pkg::action_t code_cmp1,
  input  wire timer_pkg::action_t code_wrap,
  input  wire logic              cmp0_evt,
  input  wire logic              cmp1_evt,
  input  wire logic              wrap_evt,
  input  wire logic              preset_wr,
  input  wire logic              preset_level,
  output logic                   pin
);
  import timer_pkg::*;

  action_t merged;
  logic    nxt_pin;

  // idle sources contribute keep, so the and only sees active codes
  assign merged = (cmp0_evt ? code_cmp0 : `ACT_KEEP)
                & (cmp1_evt ? code_cmp1 : `ACT_KEEP)
                & (wrap_evt ? code_wrap : `ACT_KEEP);

  always_comb begin
    unique case (merged)
      `ACT_SET:    nxt_pin = 1'b1;
      `ACT_TOGGLE: nxt_pin = ~pin;
      `ACT_CLEAR:  nxt_pin = 1'b0;
      `ACT_KEEP:   nxt_pin = pin;
    endcase
  end

  // a preset write overrides an event in the same cycle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pin <= 1'b0;
    end else begin
      pin <= preset_wr ? preset_level : nxt_pin;
    end
  end

  toggle_act_a: assert property (@(posedge core_clk) disable iff (rst)
    (!preset_wr && merged == `ACT_TOGGLE) |=> pin != $past(pin)) else $error("no toggle");
  and_merge_a: assert property (@(posedge core_clk) disable iff (rst)
    (!preset_wr && cmp0_evt && wrap_evt && code_cmp0 == `ACT_SET && code_wrap == `ACT_CLEAR)
    |=> pin) else $error("set and clear did not merge to set");
endmodule // output_action_unit

/* File: src/timer_cfg.svh */
// constants of the timer output, flag and dma control block
// assumes: included by bare name from every design file except the package, and from the testbench
//
// How it works
// - prescaler divides by preset plus one
// - new preset loads at underflow or reload
// - action codes: set, toggle, clear, keep
// - pin a: compare0, compare1, wrap fields
// - pin b: same field layout, own register
// - simultaneous actions combine by bitwise and
// - compare-event enable gives pulse per compare0 match
// - wrap-event enable gives pulse per wrap
// - write loads pin level, read returns it
// - capture0 flag set; writing one captures
// - capture1 flag; software capture except bicapture
// - compare flags set on each match
// - wrap flag set on each wrap
// - capture0 overrun on repeat or software capture
// - compare0 overrun on repeat before clear
// - combine bit selects and/or of captures
// - global enable gates every interrupt
// - dma only for capture0 and compare0
// - individual interrupt masks active at one
// - pointer high bits, bit two hardware toggled
// - dma direction bit fixed by hardware
// - area bit selects register file
`ifndef TIMER_CFG_SVH
`define TIMER_CFG_SVH

// register indices; byte address is four times the index
`define IDX_DMA_COUNT_PTR   8'hF0
`define IDX_PRESCALER       8'hFB
`define IDX_FIRST_OUT_CTL   8'hFC
`define IDX_SECOND_OUT_CTL  8'hFD
`define IDX_EVENT_FLAGS     8'hFE
`define IDX_IRQ_DMA_MASKS   8'hFF

// reset values
`define RST_PRESCALER       8'h00
`define RST_OUT_CTL         8'h00
`define RST_EVENT_FLAGS     8'h00
`define RST_IRQ_DMA_MASKS   8'h00
`define RST_DMA_PTR         8'h00

// output control fields
`define CODE_CMP0_HI        7
`define CODE_CMP1_HI        5
`define CODE_WRAP_HI        3
`define EVT_EN_BIT          1
`define PIN_LEVEL_BIT       0

// action codes
`define ACT_SET             2'h0
`define ACT_TOGGLE          2'h1
`define ACT_CLEAR           2'h2
`define ACT_KEEP            2'h3

// event flag fields
`define FLAG_CAP0           7
`define FLAG_CAP1           6
`define FLAG_CMP0           5
`define FLAG_CMP1           4
`define FLAG_WRAP           3
`define FLAG_CAP0_OVR       2
`define FLAG_CMP0_OVR       1
`define FLAG_COMBINE        0

// mask fields
`define MSK_GLOBAL          7
`define MSK_CAP0_DMA        6
`define MSK_CAP0_IRQ        5
`define MSK_CAP1_IRQ        4
`define MSK_CMP0_DMA        3
`define MSK_CMP0_IRQ        2
`define MSK_CMP1_IRQ        1
`define MSK_WRAP_IRQ        0

// dma counter pointer fields
`define PTR_TOGGLE_BIT      2
`define PTR_DIR_BIT         1
`define PTR_AREA_BIT        0

// bus responses
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2

`endif

/* File: src/timer_output_flag_dma_control.sv */
// register back end of a 16-bit multifunction timer: prescaler preset,
// output pin actions, event flags, interrupt and dma requests, dma pointer
// assumes: counter datapath events are one-cycle pulses on core_clk;
// software reaches the registers over AXI4-Lite
`timescale 1ns/1ps
`include "timer_cfg.svh"
module timer_output_flag_dma_control (
  input  wire logic                 core_clk,
  input  wire logic                 rst,
  // axi4-lite slave
  input  wire timer_pkg::axi_addr_t awaddr,
  input  wire logic                 awvalid,
  output logic                      awready,
  input  wire timer_pkg::axi_data_t wdata,
  input  wire timer_pkg::axi_strb_t wstrb,
  input  wire logic                 wvalid,
  output logic                      wready,
  output timer_pkg::axi_resp_t      bresp,
  output logic                      bvalid,
  input  wire logic                 bready,
  input  wire timer_pkg::axi_addr_t araddr,
  input  wire logic                 arvalid,
  output logic                      arready,
  output timer_pkg::axi_data_t      rdata,
  output timer_pkg::axi_resp_t      rresp,
  output logic                      rvalid,
  input  wire logic                 rready,
  // counter datapath
  input  wire logic                 prescaler_in_tick,
  input  wire logic                 counter_reload,
  input  wire logic                 counter_wrap_event,
  input  wire logic                 first_compare_match,
  input  wire logic                 second_compare_match,
  input  wire logic                 first_capture_done,
  input  wire logic                 second_capture_done,
  input  wire logic                 bicapture_mode,
  input  wire logic                 dma_pointer_swap,
  input  wire logic                 dma_direction_indicator,
  output logic                      prescaler_tick,
  output logic                      first_sw_capture,
  output logic                      second_sw_capture,
  // pins and on-chip events
  output logic                      first_output_pin,
  output logic                      second_output_pin,
  output logic                      compare_event_pulse,
  output logic                      wrap_event_pulse,
  // interrupt and dma controller
  output logic                      capture_irq_req,
  output logic                      compare_irq_req,
  output logic                      wrap_irq_req,
  output logic                      capture_dma_req,
  output logic                      compare_dma_req,
  output logic [5:0]                dma_count_address_high,
  output logic                      dma_area_register_file
);
  import timer_pkg::*;

  // ---- registers ----
  reg_byte_t prescaler_preset_ff;
  reg_byte_t first_out_ctl_ff;
  reg_byte_t second_out_ctl_ff;
  reg_byte_t flags_ff;
  reg_byte_t masks_ff;
  logic [5:0] ptr_high_ff;
  logic       ptr_area_ff;

  // ---- bus holding state ----
  logic       aw_held_ff;
  logic       w_held_ff;
  logic [9:0] wr_idx_ff;
  reg_byte_t  wr_byte_ff;
  logic       wr_lane0_ff;
  logic       wr_go;
  logic       wr_mapped;

  // write address and data are caught independently, in either order
  assign awready = !aw_held_ff && !bvalid;
  assign wready  = !w_held_ff && !bvalid;
  assign wr_go   = aw_held_ff && w_held_ff;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      aw_held_ff <= 1'b0;
      wr_idx_ff  <= 10'h000;
    end else if (awvalid && awready) begin
      aw_held_ff <= 1'b1;
      wr_idx_ff  <= awaddr[11:2];
    end else if (wr_go) begin
      aw_held_ff <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      w_held_ff   <= 1'b0;
      wr_byte_ff  <= 8'h00;
      wr_lane0_ff <= 1'b0;
    end else if (wvalid && wready) begin
      w_held_ff   <= 1'b1;
      wr_byte_ff  <= wdata[7:0];
      wr_lane0_ff <= wstrb[0];
    end else if (wr_go) begin
      w_held_ff <= 1'b0;
    end
  end

  // response: one cycle after both halves are held; unmapped gives slverr
  always_ff @(posedge core_clk) begin
    if (rst) begin
      bvalid <= 1'b0;
      bresp  <= `RESP_OKAY;
    end else if (wr_go) begin
      bvalid <= 1'b1;
      bresp  <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // ---- write decode; only byte lane 0 carries register data ----
  logic sel_ptr;
  logic sel_pre;
  logic sel_oa;
  logic sel_ob;
  logic sel_flg;
  logic sel_msk;
  logic wr_en;

  assign sel_ptr   = wr_idx_ff == {2'b00, `IDX_DMA_COUNT_PTR};
  assign sel_pre   = wr_idx_ff == {2'b00, `IDX_PRESCALER};
  assign sel_oa    = wr_idx_ff == {2'b00, `IDX_FIRST_OUT_CTL};
  assign sel_ob    = wr_idx_ff == {2'b00, `IDX_SECOND_OUT_CTL};
  assign sel_flg   = wr_idx_ff == {2'b00, `IDX_EVENT_FLAGS};
  assign sel_msk   = wr_idx_ff == {2'b00, `IDX_IRQ_DMA_MASKS};
  assign wr_mapped = sel_ptr | sel_pre | sel_oa | sel_ob | sel_flg | sel_msk;
  assign wr_en     = wr_go && wr_lane0_ff;

  logic wr_pre;
  logic wr_oa;
  logic wr_ob;
  logic wr_flg;
  logic wr_msk;
  logic wr_ptr;

  assign wr_pre = wr_en && sel_pre;
  assign wr_oa  = wr_en && sel_oa;
  assign wr_ob  = wr_en && sel_ob;
  assign wr_flg = wr_en && sel_flg;
  assign wr_msk = wr_en && sel_msk;
  assign wr_ptr = wr_en && sel_ptr;

  // plain read-write control registers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      prescaler_preset_ff <= `RST_PRESCALER;
      first_out_ctl_ff    <= `RST_OUT_CTL;
      second_out_ctl_ff   <= `RST_OUT_CTL;
      masks_ff            <= `RST_IRQ_DMA_MASKS;
    end else begin
      if (wr_pre) prescaler_preset_ff <= wr_byte_ff;
      if (wr_oa) first_out_ctl_ff <= wr_byte_ff;
      if (wr_ob) second_out_ctl_ff <= wr_byte_ff;
      if (wr_msk) masks_ff <= wr_byte_ff;
    end
  end

  // ---- event flags ----
  logic       sw_cap0;
  logic       sw_cap1;
  logic [6:0] flag_set;
  logic [6:0] flag_clr;
  reg_byte_t  nxt_flags;

  // software capture is taken only while its flag is clear
  assign sw_cap0 = wr_flg && wr_byte_ff[`FLAG_CAP0] && !flags_ff[`FLAG_CAP0];
  assign sw_cap1 = wr_flg && wr_byte_ff[`FLAG_CAP1] && !flags_ff[`FLAG_CAP1]
                 && !bicapture_mode;
  assign flag_set = {first_capture_done,
                     second_capture_done,
                     first_compare_match, second_compare_match,
                     counter_wrap_event,
                     (first_capture_done && flags_ff[`FLAG_CAP0]) || sw_cap0,
                     first_compare_match && flags_ff[`FLAG_CMP0]};
  // writing zero clears a flag; a set in the same cycle wins
  assign flag_clr = {7{wr_flg}} & ~wr_byte_ff[7:1];
  assign nxt_flags = {flag_set | (flags_ff[7:1] & ~flag_clr),
                      wr_flg ? wr_byte_ff[`FLAG_COMBINE] : flags_ff[`FLAG_COMBINE]};

  always_ff @(posedge core_clk) begin
    if (rst) begin
      flags_ff          <= `RST_EVENT_FLAGS;
      first_sw_capture  <= 1'b0;
      second_sw_capture <= 1'b0;
    end else begin
      flags_ff          <= nxt_flags;
      first_sw_capture  <= sw_cap0;
      second_sw_capture <= sw_cap1;
    end
  end

  // ---- interrupt and dma requests ----
  logic cap0_act;
  logic cap1_act;
  logic cap_pair;

  assign cap0_act = flags_ff[`FLAG_CAP0] && masks_ff[`MSK_CAP0_IRQ];
  assign cap1_act = flags_ff[`FLAG_CAP1] && masks_ff[`MSK_CAP1_IRQ];
  assign cap_pair = flags_ff[`FLAG_COMBINE] ? (cap0_act && cap1_act)
                                            : (cap0_act || cap1_act);
  assign capture_irq_req = masks_ff[`MSK_GLOBAL] && cap_pair;
  assign compare_irq_req = masks_ff[`MSK_GLOBAL]
                         && ((flags_ff[`FLAG_CMP0] && masks_ff[`MSK_CMP0_IRQ])
                          || (flags_ff[`FLAG_CMP1] && masks_ff[`MSK_CMP1_IRQ]));
  assign wrap_irq_req    = masks_ff[`MSK_GLOBAL]
                         && flags_ff[`FLAG_WRAP] && masks_ff[`MSK_WRAP_IRQ];
  // dma is not gated by the global interrupt enable
  assign capture_dma_req = flags_ff[`FLAG_CAP0] && masks_ff[`MSK_CAP0_DMA];
  assign compare_dma_req = flags_ff[`FLAG_CMP0] && masks_ff[`MSK_CMP0_DMA];

  // ---- on-chip event pulses ----
  always_ff @(posedge core_clk) begin
    if (rst) begin
      compare_event_pulse <= 1'b0;
      wrap_event_pulse    <= 1'b0;
    end else begin
      compare_event_pulse <= first_compare_match && first_out_ctl_ff[`EVT_EN_BIT];
      wrap_event_pulse    <= counter_wrap_event && second_out_ctl_ff[`EVT_EN_BIT];
    end
  end

  // ---- dma counter pointer ----
  // the swap toggle lands on top of a same-cycle write so it is never lost
  localparam reg_byte_t ptr_rst_value = `RST_DMA_PTR;

  logic bit2_base;

  assign bit2_base = wr_ptr ? wr_byte_ff[`PTR_TOGGLE_BIT] : ptr_high_ff[0];

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ptr_high_ff <= ptr_rst_value[7:2];
      ptr_area_ff <= ptr_rst_value[0];
    end else begin
      ptr_high_ff[5:1] <= wr_ptr ? wr_byte_ff[7:3] : ptr_high_ff[5:1];
      ptr_high_ff[0]   <= bit2_base ^ dma_pointer_swap;
      if (wr_ptr) ptr_area_ff <= wr_byte_ff[`PTR_AREA_BIT];
    end
  end

  assign dma_count_address_high = ptr_high_ff;
  assign dma_area_register_file = ptr_area_ff;

  // ---- helpers ----
  timer_prescaler u_prescaler (
    .core_clk (core_clk),
    .rst      (rst),
    .in_tick  (prescaler_in_tick),
    .reload   (counter_reload),
    .preset   (prescaler_preset_ff),
    .out_tick (prescaler_tick)
  );

  output_action_unit u_first_pin (
    .core_clk     (core_clk),
    .rst          (rst),
    .code_cmp0    (first_out_ctl_ff[`CODE_CMP0_HI -: 2]),
    .code_cmp1    (first_out_ctl_ff[`CODE_CMP1_HI -: 2]),
    .code_wrap    (first_out_ctl_ff[`CODE_WRAP_HI -: 2]),
    .cmp0_evt     (first_compare_match),
    .cmp1_evt     (second_compare_match),
    .wrap_evt     (counter_wrap_event),
    .preset_wr    (wr_oa),
    .preset_level (wr_byte_ff[`PIN_LEVEL_BIT]),
    .pin          (first_output_pin)
  );

  output_action_unit u_second_pin (
    .core_clk     (core_clk),
    .rst          (rst),
    .code_cmp0    (second_out_ctl_ff[`CODE_CMP0_HI -: 2]),
    .code_cmp1    (second_out_ctl_ff[`CODE_CMP1_HI -: 2]),
    .code_wrap    (second_out_ctl_ff[`CODE_WRAP_HI -: 2]),
    .cmp0_evt     (first_compare_match),
    .cmp1_evt     (second_compare_match),
    .wrap_evt     (counter_wrap_event),
    .preset_wr    (wr_ob),
    .preset_level (wr_byte_ff[`PIN_LEVEL_BIT]),
    .pin          (second_output_pin)
  );

  // ---- read path ----
  logic [9:0] rd_idx;
  reg_byte_t  rd_byte;
  logic       rd_mapped;

  assign arready = !rvalid;
  assign rd_idx  = araddr[11:2];
  // pin level bit reads back the live pin, not the written preset
  assign rd_byte =
    (rd_idx == {2'b00, `IDX_DMA_COUNT_PTR}) ?
      {ptr_high_ff, dma_direction_indicator, ptr_area_ff} :
    (rd_idx == {2'b00, `IDX_PRESCALER})     ? prescaler_preset_ff :
    (rd_idx == {2'b00, `IDX_FIRST_OUT_CTL}) ?
      {first_out_ctl_ff[7:1], first_output_pin} :
    (rd_idx == {2'b00, `IDX_SECOND_OUT_CTL}) ?
      {second_out_ctl_ff[7:1], second_output_pin} :
    (rd_idx == {2'b00, `IDX_EVENT_FLAGS})   ? flags_ff :
    (rd_idx == {2'b00, `IDX_IRQ_DMA_MASKS}) ? masks_ff : 8'h00;
  assign rd_mapped = rd_idx >= {2'b00, `IDX_PRESCALER} || rd_idx == {2'b00, `IDX_DMA_COUNT_PTR};

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= `RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata  <= {24'h000000, rd_byte};
      rresp  <= (rd_mapped && rd_idx <= {2'b00, `IDX_IRQ_DMA_MASKS}) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // ---- checks ----
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence sw_cap0_req;
    wr_flg && wr_byte_ff[`FLAG_CAP0] && !flags_ff[`FLAG_CAP0];
  endsequence
  sequence sw_cap0_seen;
    first_sw_capture && flags_ff[`FLAG_CAP0_OVR];
  endsequence

  wrap_flag_set_a: assert property (counter_wrap_event |=> flags_ff[`FLAG_WRAP])
    else $error("wrap flag not set");
  cmp_flags_set_a: assert property ((first_compare_match && second_compare_match)
    |=> flags_ff[`FLAG_CMP0] && flags_ff[`FLAG_CMP1]) else $error("compare flags not set");
  cap_flag_set_a: assert property (first_capture_done |=> flags_ff[`FLAG_CAP0])
    else $error("capture0 flag not set");
  sw_cap_ovr_a: assert property (sw_cap0_req |=> sw_cap0_seen)
    else $error("software capture lacks pulse or overrun");
  cmp_overrun_a: assert property ((first_compare_match && flags_ff[`FLAG_CMP0])
    |=> flags_ff[`FLAG_CMP0_OVR]) else $error("compare overrun missed");
  bicap_block_a: assert property (bicapture_mode |=> !second_sw_capture)
    else $error("software capture1 in bicapture mode");
  global_gate_a: assert property (!masks_ff[`MSK_GLOBAL]
    |-> !capture_irq_req && !compare_irq_req && !wrap_irq_req) else $error("irq ungated");
  cap_and_a: assert property ((flags_ff[`FLAG_COMBINE] && !flags_ff[`FLAG_CAP1])
    |-> !capture_irq_req) else $error("and combine ignored");
  wrap_irq_a: assert property ((masks_ff[`MSK_GLOBAL] && masks_ff[`MSK_WRAP_IRQ]
    && counter_wrap_event && !wr_msk) |=> wrap_irq_req) else $error("wrap irq not raised");
  dma_req_a: assert property ((masks_ff[`MSK_CMP0_DMA] && first_compare_match
    && !wr_msk) |=> compare_dma_req) else $error("compare dma missing");
  cmp_pulse_a: assert property (compare_event_pulse
    |-> $past(first_compare_match) && $past(first_out_ctl_ff[`EVT_EN_BIT]))
    else $error("stray compare event");
  wrap_pulse_a: assert property ((counter_wrap_event && second_out_ctl_ff[`EVT_EN_BIT])
    |=> wrap_event_pulse ##1 !wrap_event_pulse || $past(counter_wrap_event, 1) == 1'b1)
    else $error("wrap event pulse wrong");
  preset_pin_a: assert property (wr_oa |=> first_output_pin == $past(wr_byte_ff[0]))
    else $error("pin preset not applied");
  ptr_toggle_a: assert property ((dma_pointer_swap && !wr_ptr)
    |=> ptr_high_ff[0] != $past(ptr_high_ff[0])) else $error("pointer bit not toggled");
  area_bit_a: assert property (wr_ptr |=> dma_area_register_file == $past(wr_byte_ff[0]))
    else $error("area bit not written");
endmodule // timer_output_flag_dma_control

/* File: src/timer_pkg.sv */
// types shared by the timer control block and its helpers
// assumes: constants come from timer_cfg.svh
package timer_pkg;
  typedef logic [7:0]  reg_byte_t;
  typedef logic [1:0]  action_t;
  typedef logic [11:0] axi_addr_t;
  typedef logic [31:0] axi_data_t;
  typedef logic [3:0]  axi_strb_t;
  typedef logic [1:0]  axi_resp_t;
endpackage

/* File: src/timer_prescaler.sv */
// down-counting prescaler giving a one-cycle tick every preset+1 input ticks
// assumes: in_tick and reload come from logic on core_clk
`timescale 1ns/1ps
`include "timer_cfg.svh"
module timer_prescaler (
  input  wire logic               core_clk,
  input  wire logic               rst,
  input  wire logic               in_tick,
  input  wire logic               reload,
  input  wire timer_pkg::reg_byte_t preset,
  output logic                    out_tick
);
  import timer_pkg::*;

  reg_byte_t cnt_ff;
  reg_byte_t nxt_cnt;
  logic      underflow;

  // a fresh preset only enters the count here, never mid-count
  assign underflow = in_tick && (cnt_ff == 8'h00);
  assign nxt_cnt   = (reload || underflow) ? preset : cnt_ff - 8'h01;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt_ff   <= `RST_PRESCALER;
      out_tick <= 1'b0;
    end else begin
      out_tick <= underflow;
      if (reload || in_tick) begin
        cnt_ff <= nxt_cnt;
      end
    end
  end

  reload_load_a: assert property (@(posedge core_clk) disable iff (rst)
    reload |=> cnt_ff == $past(preset)) else $error("reload did not load preset");
  zero_pass_a: assert property (@(posedge core_clk) disable iff (rst)
    (in_tick && !reload && cnt_ff == 8'h00) |=> out_tick) else $error("underflow missed");
endmodule // timer_prescaler

/* File: verif/dma_grant_model.sv */
// dma controller model: grants each compare dma request once
// assumes: requests are levels on core_clk held until the flag clears
`timescale 1ns/1ps
module dma_grant_model (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       req,
  output logic      [7:0] grants
);
  logic req_ff;
  // count rising requests; a held level is one transfer, not one per cycle
  always_ff @(posedge core_clk) begin
    req_ff <= rst ? 1'b0 : req;
    grants <= rst ? 8'h00 : grants + {7'h00, req & !req_ff};
  end
endmodule // dma_grant_model

/* File: verif/tb.sv */
// testbench: register accesses and datapath pulses against expected values
// assumes: timer_cfg.svh on the include path, one axi4-lite master here
`timescale 1ns/1ps
`include "timer_cfg.svh"
module tb;
  import timer_pkg::*;
  logic       core_clk, rst, awvalid, wvalid, bready, arvalid, rready, tk, ld;
  logic       awready, wready, bvalid, arready, rvalid, pt, cep, wep, p1, p2, mi, wi, md;
  logic       area;
  logic       bic, swp, dir, s1, s2, ci, cd;
  logic [5:0] dah;
  logic [4:0] ev;
  logic [1:0] pp;
  logic [7:0] grants;
  axi_addr_t  awaddr, araddr;
  axi_data_t  wdata, rdata;
  axi_resp_t  bresp, rresp;
  int         n_mismatch, compares, cyc, k;

  timer_output_flag_dma_control timer_output_flag_dma_control_inst (
    .core_clk, .rst, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'h1), .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .prescaler_in_tick(tk), .counter_reload(ld), .counter_wrap_event(ev[0]),
    .first_compare_match(ev[1]), .second_compare_match(ev[2]), .first_capture_done(ev[3]),
    .second_capture_done(ev[4]), .bicapture_mode(bic), .dma_pointer_swap(swp),
    .dma_direction_indicator(dir), .prescaler_tick(pt), .first_sw_capture(s1),
    .second_sw_capture(s2), .first_output_pin(p1), .second_output_pin(p2),
    .compare_event_pulse(cep), .wrap_event_pulse(wep), .capture_irq_req(ci),
    .compare_irq_req(mi), .wrap_irq_req(wi), .capture_dma_req(cd), .compare_dma_req(md),
    .dma_count_address_high(dah), .dma_area_register_file(area));

  dma_grant_model dma_grant_model_inst (.core_clk, .rst, .req(md), .grants);

  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    compares++;
    if (s !== e) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask

  // bready stays high, so a new write never lowers and raises it in one step
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    awaddr <= {2'h0, i, 2'h0};
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge core_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    chk({6'h00, bresp}, {6'h00, `RESP_OKAY});
  endtask

  task automatic rd(input logic [7:0] i, input logic [7:0] e, input logic [1:0] r);
    araddr <= {2'h0, i, 2'h0};
    arvalid <= 1'b1;
    do begin
      @(posedge core_clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    chk(rdata[7:0], e);
    chk({6'h00, rresp}, {6'h00, r});
  endtask

  // one-cycle datapath pulse; event pulses are caught mid-cycle after it
  task automatic ev_p(input logic [4:0] v);
    ev <= v;
    @(posedge core_clk);
    ev <= 5'h00;
    @(negedge core_clk);
    pp = {cep, wep};
    @(posedge core_clk);
  endtask

  task automatic end_of_test;
    if (n_mismatch == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // watchdog: the run needs under a hundred cycles
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  initial begin
    {rst, awvalid, wvalid, arvalid, tk, ld, bready, rready} = 8'h83;
    {bic, swp, dir} = 3'h1;
    {awaddr, araddr, wdata, ev} = '0;
    n_mismatch = 0;
    compares = 0;
    cyc = 0;
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    rd(`IDX_IRQ_DMA_MASKS, 8'h00, `RESP_OKAY);
    rd(`IDX_EVENT_FLAGS, 8'h00, `RESP_OKAY);
    rd(8'h10, 8'h00, `RESP_SLVERR);
    wr(`IDX_FIRST_OUT_CTL, 8'h7A);
    ev_p(5'h02);
    chk({6'h00, pp}, 8'h02);
    chk({6'h00, p1, p2}, 8'h03);
    rd(`IDX_FIRST_OUT_CTL, 8'h7B, `RESP_OKAY);
    ev_p(5'h01);
    chk({6'h00, p1, pp[0]}, 8'h00);
    ev_p(5'h03);
    chk({7'h00, p1}, 8'h01);
    rd(`IDX_EVENT_FLAGS, 8'h2A, `RESP_OKAY);
    wr(`IDX_IRQ_DMA_MASKS, 8'h8D);
    chk({5'h00, mi, wi, md}, 8'h07);
    wr(`IDX_IRQ_DMA_MASKS, 8'h0D);
    chk({5'h00, mi, wi, md}, 8'h01);
    chk(grants, 8'h01);
    wr(`IDX_SECOND_OUT_CTL, 8'hFE);
    ev_p(5'h01);
    chk({5'h00, pp, p2}, 8'h02);
    wr(`IDX_EVENT_FLAGS, 8'h80);
    chk({7'h00, s1}, 8'h01);
    rd(`IDX_EVENT_FLAGS, 8'h04, `RESP_OKAY);
    ev_p(5'h08);
    rd(`IDX_EVENT_FLAGS, 8'h84, `RESP_OKAY);
    wr(`IDX_PRESCALER, 8'h02);
    ld <= 1'b1;
    tk <= 1'b1;
    @(posedge core_clk);
    ld <= 1'b0;
    while (!pt) @(posedge core_clk);
    @(posedge core_clk);
    k = 1;
    while (!pt) begin
      @(posedge core_clk);
      k++;
    end
    chk(k[7:0], 8'h03);
    tk <= 1'b0;
    wr(`IDX_DMA_COUNT_PTR, 8'hFD);
    rd(`IDX_DMA_COUNT_PTR, 8'hFF, `RESP_OKAY);
    chk({dah, area, 1'b0}, 8'hFE);
    // swap pulse flips pointer bit two; direction bit follows the datapath level
    dir <= 1'b0;
    swp <= 1'b1;
    @(posedge core_clk);
    swp <= 1'b0;
    rd(`IDX_DMA_COUNT_PTR, 8'hF9, `RESP_OKAY);
    bic <= 1'b1;
    wr(`IDX_EVENT_FLAGS, 8'h40);
    chk({7'h00, s2}, 8'h00);
    bic <= 1'b0;
    wr(`IDX_EVENT_FLAGS, 8'h40);
    chk({7'h00, s2}, 8'h01);
    wr(`IDX_IRQ_DMA_MASKS, 8'hF1);
    ev_p(5'h09);
    chk({5'h00, ci, cd, wi}, 8'h07);
    wr(`IDX_EVENT_FLAGS, 8'h89);
    chk({7'h00, ci}, 8'h00);
    ev_p(5'h10);
    chk({7'h00, ci}, 8'h01);
    end_of_test();
  end
endmodule // tb
